/* File: dv/pmcg_chk.sv */
// checker: port-level relations of the power controller
`timescale 1ns/1ps
module pmcg_chk
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] power_mode,
   input wire logic cpu_halted,
   input wire logic uart_clk_en,
   input wire logic spi_clk_en,
   input wire logic i2c_clk_en,
   input wire logic rtc_clk_en,
   input wire logic comparator_enable,
   input wire logic brownout_enable,
   input wire logic brownout_reset_req,
   input wire logic user_flag_a,
   input wire logic user_flag_b
);
   logic acc;
   logic mapped;
   // access phase and address decode
   assign acc = psel && penable;
   assign mapped = paddr inside {pmcg_pkg::PMCG_ADDR_PCTL,
      pmcg_pkg::PMCG_ADDR_PGATE, 12'h400, 12'h404, 12'h408, 12'h40C};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // register write strobes
   sequence s_wr_pctl;
      acc && pwrite && paddr == pmcg_pkg::PMCG_ADDR_PCTL;
   endsequence
   sequence s_wr_gate;
      acc && pwrite && paddr == pmcg_pkg::PMCG_ADDR_PGATE;
   endsequence
   a_ready_high: assert property (psel |-> pready)
      else $error("pready low");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("no slave error");
   a_read_idle: assert property (!$past(psel && !penable && !pwrite) |->
      prdata == '0)
      else $error("read data not zero");
   a_flag_store: assert property (s_wr_pctl |=>
      {user_flag_b, user_flag_a} == $past(pwdata[3:2]))
      else $error("user flags wrong");
   a_mode_store: assert property (s_wr_pctl |=>
      power_mode == $past(pwdata[1:0]))
      else $error("mode field wrong");
   a_halt_enter: assert property (s_wr_pctl ##0 pwdata[1] |->
      ##[1:2] cpu_halted)
      else $error("no halt");
   a_gate_store: assert property (
      s_wr_gate ##1 !power_mode[1] |->
      {rtc_clk_en, i2c_clk_en, spi_clk_en, uart_clk_en} ==
      ~{$past(pwdata[7]), $past(pwdata[3:1])})
      else $error("clock gates wrong");
   a_pd_gates: assert property ($rose(power_mode[1]) |->
      ##[0:1] !(uart_clk_en || spi_clk_en || i2c_clk_en))
      else $error("clocks run in power-down");
   a_tpd_off: assert property (power_mode == 2'h3 && cpu_halted |->
      !brownout_enable && !comparator_enable && !brownout_reset_req)
      else $error("brownout on in total power-down");
endmodule

/* File: dv/testbench.sv */
// testbench: registers, gating, modes and wake of the power controller
`timescale 1ns/1ps
module testbench;
   localparam logic [11:0] AC = pmcg_pkg::PMCG_ADDR_PCTL;
   localparam logic [11:0] AG = pmcg_pkg::PMCG_ADDR_PGATE;
   localparam logic [11:0] AS = pmcg_pkg::PMCG_ADDR_IRQ_STATUS;
   localparam logic [11:0] AM = pmcg_pkg::PMCG_ADDR_IRQ_MASK;
   localparam logic [11:0] AW = pmcg_pkg::PMCG_ADDR_WAKE_CFG;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic brownout_pin, comparator_event, watchdog_clock_select;
   logic watchdog_event, keyboard_irq, rtc_event, osc_tick;
   logic t1_overflow, serial_mode_bit, framing_error_status;
   logic serial_bit7, baud_tick, cpu_halted, osc_run, uart_clk_en;
   logic spi_clk_en, i2c_clk_en, rtc_clk_en, comparator_enable;
   logic brownout_enable, brownout_reset_req, watchdog_reset_req;
   logic user_flag_a, user_flag_b, irq;
   logic [1:0] external_irq_inputs, power_mode;
   int err_count, compares, ticks, n;
   // table rows: address, write value, read-back value
   logic [11:0] ra [6] = '{AC, AC, AG, AG, AM, AW};
   logic [31:0] rw [6] = '{32'hFC, 32'h20, 32'hFF, 32'h51, 32'h3, 32'h5};
   logic [31:0] rx [6] = '{32'hDC, 32'h0, 32'hAE, 32'h0, 32'h3, 32'h5};

   pmcg_top i_dut (.*);

   // clock generation
   initial
   begin
      pclk = 1'b0;
      forever
         #2.5 pclk = ~pclk;
   end

   // baud tick counter
   always @(posedge pclk)
      if (baud_tick === 1'b1)
         ticks++;

   task automatic wt(input int c);
      repeat (c)
         @(posedge pclk);
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x)
      begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask

   task automatic chk_b(input logic g, input logic x);
      compares++;
      if (g !== x)
      begin
         err_count++;
         $display("ERROR %0t flag %b exp %b", $time, g, x);
      end
   endtask

   // one apb transfer; read data and error taken at the access edge
   task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      e = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // raise wake sources briefly, count cycles until running
   task automatic wake(input logic [3:0] s);
      {rtc_event, watchdog_event, external_irq_inputs[0], keyboard_irq} <= s;
      n = 0;
      while (cpu_halted === 1'b1 && n < 1200)
      begin
         @(posedge pclk);
         n++;
         if (n == 4)
            {rtc_event, watchdog_event, external_irq_inputs[0],
               keyboard_irq} <= '0;
      end
   endtask

   task automatic test_done();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // watchdog against hangs
   initial
   begin
      repeat (20000)
         @(posedge pclk);
      err_count++;
      test_done();
   end

   // main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {brownout_pin, comparator_event, watchdog_clock_select} = '0;
      {watchdog_event, external_irq_inputs, keyboard_irq} = '0;
      {rtc_event, osc_tick, t1_overflow} = '0;
      {serial_mode_bit, framing_error_status} = '0;
      err_count = 0;
      compares = 0;
      ticks = 0;
      presetn = 1'b0;
      wt(5);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({uart_clk_en, spi_clk_en, i2c_clk_en, rtc_clk_en, irq},
         5'h1E);
      apb(AC, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(AG, 1'b0, 32'h0);
      chk(rd, 32'h0);
      // table of write and read-back rows
      for (int i = 0; i < 6; i++)
      begin
         apb(ra[i], 1'b1, rw[i]);
         apb(ra[i], 1'b0, 32'h0);
         chk(rd, rx[i]);
      end
      apb(12'h100, 1'b0, 32'h0);
      chk_b(e, 1'b1);
      chk(rd, 32'h0);
      // comparator events held idle, then gates and power-down
      apb(AG, 1'b1, 32'hAE);
      chk({uart_clk_en, spi_clk_en, i2c_clk_en, rtc_clk_en,
         comparator_enable}, 5'h0);
      apb(AG, 1'b1, 32'h0);
      chk({uart_clk_en, spi_clk_en, i2c_clk_en, rtc_clk_en,
         comparator_enable}, 5'h1F);
      // flags and serial bit 7 steering
      serial_mode_bit <= 1'b1;
      apb(AC, 1'b1, 32'h0C);
      wt(2);
      chk({serial_bit7, user_flag_b, user_flag_a}, 3'h7);
      apb(AC, 1'b1, 32'h40);
      wt(2);
      chk({serial_bit7, user_flag_b, user_flag_a}, 3'h0);
      // baud rate halved or direct
      for (int b = 0; b < 2; b++)
      begin
         apb(AC, 1'b1, {24'h0, b[0], 7'h0});
         ticks = 0;
         repeat (4)
         begin
            t1_overflow <= 1'b1;
            @(posedge pclk);
            t1_overflow <= 1'b0;
            wt(3);
         end
         chk(ticks, b ? 32'h4 : 32'h2);
      end
      // brownout interrupt, read clear, then irq low
      apb(AM, 1'b1, 32'h1);
      apb(AC, 1'b1, 32'h10);
      brownout_pin <= 1'b1;
      wt(6);
      chk_b(irq, 1'b1);
      brownout_pin <= 1'b0;
      wt(4);
      apb(AS, 1'b0, 32'h0);
      chk(rd, 32'h1);
      chk_b(irq, 1'b0);
      // idle halts but leaves clocks on
      apb(AC, 1'b1, 32'h1);
      wt(2);
      chk({cpu_halted, uart_clk_en}, 2'h3);
      apb(AC, 1'b1, 32'h0);
      wt(2);
      chk_b(cpu_halted, 1'b0);
      // power-down woken by keyboard, level irq, watchdog, rtc
      for (int s = 0; s < 4; s++)
      begin
         watchdog_clock_select <= (s == 2);
         if (s == 3)
            apb(AW, 1'b1, 32'h7);
         apb(AC, 1'b1, 32'h2);
         wt(3);
         chk({power_mode, cpu_halted, uart_clk_en, spi_clk_en, i2c_clk_en,
            osc_run}, {6'h28, s == 3});
         wake(4'h1 << s);
         chk_b(n >= 1024 && n <= 1040, 1'b1);
         chk({power_mode, cpu_halted}, 3'h0);
      end
      // total power-down ignores brownout
      apb(AC, 1'b1, 32'h13);
      {brownout_pin, watchdog_event} <= 2'h3;
      wt(10);
      chk({cpu_halted, brownout_enable, comparator_enable,
         brownout_reset_req, watchdog_reset_req}, 5'h10);
      {brownout_pin, watchdog_event} <= 2'h0;
      wt(4);
      wake(4'h1);
      apb(AS, 1'b0, 32'h0);
      chk(rd, 32'h2);
      test_done();
   end
endmodule

bind pmcg_top pmcg_chk i_chk (.*);

/* File: rtl/pmcg_baud_div.sv */
// module: baud tick selection with optional divide by two
`timescale 1ns/1ps
module pmcg_baud_div
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic t1_overflow,
   input wire logic baud_doubler,
   output logic baud_tick
);
   typedef struct packed
   {
      logic half;
      logic tick;
   } pmcg_bd_s;
   pmcg_bd_s st_reg;
   pmcg_bd_s st_next;

   // pass overflow through or halve it
   always_comb
   begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (clk_en && t1_overflow)
      begin
         if (baud_doubler)
            st_next.tick = 1'b1; // [R10]
         else
         begin
            st_next.tick = st_reg.half; // [R10]
            st_next.half = ~st_reg.half;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign baud_tick = st_reg.tick;
endmodule

/* File: rtl/pmcg_pkg.sv */
// package: register map, field positions and timing of the power controller
package pmcg_pkg;
   // apb byte addresses (index times four)
   localparam logic [7:0] PMCG_IDX_PCTL = 8'h87;
   localparam logic [7:0] PMCG_IDX_PGATE = 8'hB5;
   localparam logic [11:0] PMCG_ADDR_PCTL = {2'h0, PMCG_IDX_PCTL, 2'h0};
   localparam logic [11:0] PMCG_ADDR_PGATE = {2'h0, PMCG_IDX_PGATE, 2'h0};
   localparam logic [11:0] PMCG_ADDR_IRQ_STATUS = 12'h400;
   localparam logic [11:0] PMCG_ADDR_IRQ_MASK = 12'h404;
   localparam logic [11:0] PMCG_ADDR_WAKE_CFG = 12'h408;
   localparam logic [11:0] PMCG_ADDR_STATE = 12'h40C;
   // power_control fields
   localparam int PMCG_POS_MODE = 0;
   localparam int PMCG_POS_FLAG_A = 2;
   localparam int PMCG_POS_FLAG_B = 3;
   localparam int PMCG_POS_BOI_EN = 4;
   localparam int PMCG_POS_FE_LOC = 6;
   localparam int PMCG_POS_BAUD_DBL = 7;
   localparam logic [7:0] PMCG_PCTL_MASK = 8'hDF;
   // peripheral_power_gate fields
   localparam int PMCG_POS_UART_GATE = 1;
   localparam int PMCG_POS_SPI_GATE = 2;
   localparam int PMCG_POS_I2C_GATE = 3;
   localparam int PMCG_POS_CMP_PD = 5;
   localparam int PMCG_POS_RTC_GATE = 7;
   localparam logic [7:0] PMCG_PGATE_MASK = 8'hAE;
   // wake configuration fields
   localparam int PMCG_POS_XTAL_SEL = 0;
   localparam int PMCG_POS_RTC_ON_XTAL = 1;
   localparam int PMCG_POS_EXT0_LEVEL = 2;
   localparam int PMCG_POS_EXT1_LEVEL = 3;
   // reset values
   localparam logic [7:0] PMCG_PCTL_RESET = 8'h00;
   localparam logic [7:0] PMCG_PGATE_RESET = 8'h00;
   localparam logic [3:0] PMCG_WAKE_RESET = 4'h1;
   // interrupt status bits
   localparam int PMCG_IRQ_BROWNOUT = 0;
   localparam int PMCG_IRQ_WAKE = 1;
   localparam int PMCG_IRQ_W = 2;
   // power modes
   typedef enum logic [1:0]
   {
      PMCG_MODE_NORMAL = 2'h0,
      PMCG_MODE_IDLE = 2'h1,
      PMCG_MODE_PD = 2'h2,
      PMCG_MODE_TPD = 2'h3
   } pmcg_mode_e;
   // oscillator start-up delays
   localparam int PMCG_XTAL_WAKE_CLKS = 1024;
   localparam int PMCG_EXT_WAKE_CYCLES = 32;
   localparam int PMCG_CNT_W = 11;
endpackage

/* File: rtl/pmcg_top.sv */
// module: power mode control, peripheral clock gating and wake-up
// Function
// R01 - mode field selects normal, idle, power-down, total
// R02 - total power-down disables brownout and comparators
// R03 - wake delay 1024 clocks crystal, 32 external
// R04 - watchdog on its own clock wakes device
// R05 - level external irqs and keyboard wake device
// R06 - rtc wakes; crystal kept unless rtc gated; code keeps it in power-down only with the wake_cfg rtc-on-crystal bit set
// R07 - two user flags, plain storage only
// R08 - brownout enable bit raises brownout interrupt
// R09 - location bit steers serial bit 7 access
// R10 - baud doubler selects direct or halved rate
// R11 - uart clock gated by bit or power-down
// R12 - spi clock gated by bit or power-down
// R13 - i2c clock gated by bit or power-down
// R14 - comparator power-down bit powers comparators down
// R15 - software disables comparators before power-down bit
// R16 - rtc clock gate bit stops rtc clock
// R17 - reserved bits read zero, writes ignored
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module pmcg_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic brownout_pin,
   input wire logic comparator_event,
   input wire logic watchdog_clock_select,
   input wire logic watchdog_event,
   input wire logic [1:0] external_irq_inputs,
   input wire logic keyboard_irq,
   input wire logic rtc_event,
   input wire logic osc_tick,
   input wire logic t1_overflow,
   input wire logic serial_mode_bit,
   input wire logic framing_error_status,
   output logic serial_bit7,
   output logic baud_tick,
   output logic [1:0] power_mode,
   output logic cpu_halted,
   output logic osc_run,
   output logic uart_clk_en,
   output logic spi_clk_en,
   output logic i2c_clk_en,
   output logic rtc_clk_en,
   output logic comparator_enable,
   output logic brownout_enable,
   output logic brownout_reset_req,
   output logic watchdog_reset_req,
   output logic user_flag_a,
   output logic user_flag_b,
   output logic irq
);
   typedef enum logic [3:0]
   {
      PMCG_ST_RUN = 4'h1,
      PMCG_ST_IDLE = 4'h2,
      PMCG_ST_SLEEP = 4'h4,
      PMCG_ST_WARM = 4'h8
   } pmcg_state_e;

   typedef struct packed
   {
      logic [7:0] pctl;
      logic [7:0] pgate;
      logic [3:0] wake_cfg;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      pmcg_state_e state;
      logic [10:0] count;
      logic [31:0] rdata;
      logic [1:0] bo_sync;
      logic [1:0] cmp_sync;
      logic [1:0] wd_sync;
      logic [1:0] wdsel_sync;
      logic [1:0] ext0_sync;
      logic [1:0] ext1_sync;
      logic [1:0] kbd_sync;
      logic [1:0] rtc_sync;
      logic [1:0] osc_sync;
      logic [1:0] sm_sync;
      logic [1:0] fe_sync;
      logic osc_last;
      logic bo_last;
   } pmcg_s;

   pmcg_s st_reg;
   pmcg_s st_next;

   logic access;
   logic wr;
   logic rd;
   logic [1:0] mode;
   logic power_down;
   logic total_pd;
   logic wake;
   logic osc_edge;
   logic bo_rise;
   logic [10:0] wake_len;
   logic [1:0] irq_set;
   logic mapped;
   logic setup_rd;
   logic [31:0] rd_word;
   logic warm_step;
   logic warm_done;

   // apb decode, zero wait states
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   // read data is fetched in setup so it stands through access
   assign setup_rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   // unmapped offsets answer with an error
   assign mapped = paddr == pmcg_pkg::PMCG_ADDR_PCTL
      || paddr == pmcg_pkg::PMCG_ADDR_PGATE
      || paddr == pmcg_pkg::PMCG_ADDR_IRQ_STATUS
      || paddr == pmcg_pkg::PMCG_ADDR_IRQ_MASK
      || paddr == pmcg_pkg::PMCG_ADDR_WAKE_CFG
      || paddr == pmcg_pkg::PMCG_ADDR_STATE;
   assign pslverr = access && !mapped; // [R17]

   // mode decode
   assign mode = st_reg.pctl[pmcg_pkg::PMCG_POS_MODE +: 2]; // [R01]
   assign power_down = mode[1]; // [R01]
   assign total_pd = (mode == pmcg_pkg::PMCG_MODE_TPD); // [R01]

   // edge detection on synchronised inputs
   assign osc_edge = st_reg.osc_sync[1] && !st_reg.osc_last;
   assign bo_rise = st_reg.bo_sync[1] && !st_reg.bo_last;

   // wake sources from power-down
   always_comb
   begin
      wake = 1'b0;
      if (st_reg.wdsel_sync[1] && st_reg.wd_sync[1])
         wake = 1'b1; // [R04]
      if (st_reg.wake_cfg[pmcg_pkg::PMCG_POS_EXT0_LEVEL]
         && st_reg.ext0_sync[1])
         wake = 1'b1; // [R05]
      if (st_reg.wake_cfg[pmcg_pkg::PMCG_POS_EXT1_LEVEL]
         && st_reg.ext1_sync[1])
         wake = 1'b1; // [R05]
      if (st_reg.kbd_sync[1])
         wake = 1'b1; // [R05]
      if (st_reg.rtc_sync[1]
         && !st_reg.pgate[pmcg_pkg::PMCG_POS_RTC_GATE])
         wake = 1'b1; // [R06]
      if (!total_pd && (st_reg.cmp_sync[1]
         || (st_reg.bo_sync[1]
         && st_reg.pctl[pmcg_pkg::PMCG_POS_BOI_EN])))
         wake = 1'b1; // [R02]
   end

   // start-up length by oscillator kind
   assign wake_len = st_reg.wake_cfg[pmcg_pkg::PMCG_POS_XTAL_SEL]
      ? 11'(pmcg_pkg::PMCG_XTAL_WAKE_CLKS)
      : 11'(pmcg_pkg::PMCG_EXT_WAKE_CYCLES); // [R03]

   // warm-up step: every clock on crystal, osc edges otherwise
   assign warm_step = st_reg.wake_cfg[pmcg_pkg::PMCG_POS_XTAL_SEL]
      || osc_edge; // [R03]
   assign warm_done = (st_reg.state == PMCG_ST_WARM)
      && (st_reg.count == 11'h001) && warm_step; // [R03]

   // interrupt events
   always_comb
   begin
      irq_set = '0;
      irq_set[pmcg_pkg::PMCG_IRQ_BROWNOUT] = bo_rise && !total_pd
         && st_reg.pctl[pmcg_pkg::PMCG_POS_BOI_EN]; // [R08] [R02]
      irq_set[pmcg_pkg::PMCG_IRQ_WAKE] = warm_done;
   end

   // read multiplexer, reserved bits read zero
   always_comb
   begin
      rd_word = '0;
      unique case (paddr)
         pmcg_pkg::PMCG_ADDR_PCTL:
            rd_word = {24'h0, st_reg.pctl}; // [R07] [R17]
         pmcg_pkg::PMCG_ADDR_PGATE:
            rd_word = {24'h0, st_reg.pgate}; // [R17]
         pmcg_pkg::PMCG_ADDR_IRQ_STATUS:
            rd_word = {30'h0, st_reg.irq_status};
         pmcg_pkg::PMCG_ADDR_IRQ_MASK:
            rd_word = {30'h0, st_reg.irq_mask};
         pmcg_pkg::PMCG_ADDR_WAKE_CFG:
            rd_word = {28'h0, st_reg.wake_cfg};
         pmcg_pkg::PMCG_ADDR_STATE:
            rd_word = {17'h0, st_reg.count, st_reg.state};
         default:
            rd_word = '0;
      endcase
   end

   // next state
   always_comb
   begin
      st_next = st_reg;
      st_next.rdata = '0;
      // two-flop synchronisers on pin inputs
      st_next.bo_sync = {st_reg.bo_sync[0], brownout_pin};
      st_next.cmp_sync = {st_reg.cmp_sync[0], comparator_event};
      st_next.wd_sync = {st_reg.wd_sync[0], watchdog_event};
      st_next.wdsel_sync = {st_reg.wdsel_sync[0], watchdog_clock_select};
      st_next.ext0_sync = {st_reg.ext0_sync[0], external_irq_inputs[0]};
      st_next.ext1_sync = {st_reg.ext1_sync[0], external_irq_inputs[1]};
      st_next.kbd_sync = {st_reg.kbd_sync[0], keyboard_irq};
      st_next.rtc_sync = {st_reg.rtc_sync[0], rtc_event};
      st_next.osc_sync = {st_reg.osc_sync[0], osc_tick};
      st_next.sm_sync = {st_reg.sm_sync[0], serial_mode_bit};
      st_next.fe_sync = {st_reg.fe_sync[0], framing_error_status};
      st_next.osc_last = st_reg.osc_sync[1];
      st_next.bo_last = st_reg.bo_sync[1];

      // register writes, reserved bits dropped
      if (wr)
      begin
         unique case (paddr)
            pmcg_pkg::PMCG_ADDR_PCTL:
               st_next.pctl = pwdata[7:0] & pmcg_pkg::PMCG_PCTL_MASK; // [R17]
            pmcg_pkg::PMCG_ADDR_PGATE:
               st_next.pgate = pwdata[7:0] & pmcg_pkg::PMCG_PGATE_MASK; // [R17]
            pmcg_pkg::PMCG_ADDR_IRQ_MASK:
               st_next.irq_mask = pwdata[1:0];
            pmcg_pkg::PMCG_ADDR_WAKE_CFG:
               st_next.wake_cfg = pwdata[3:0];
            default:
               st_next.rdata = '0;
         endcase
      end

      // read word captured in setup, stands through access
      if (setup_rd)
         st_next.rdata = rd_word;

      // status bits that were read are cleared
      if (rd && paddr == pmcg_pkg::PMCG_ADDR_IRQ_STATUS)
         st_next.irq_status = st_reg.irq_status & ~st_reg.rdata[1:0];
      // new events set sticky bits after any clear
      st_next.irq_status = st_next.irq_status | irq_set;

      // power state sequence
      unique case (st_reg.state)
         PMCG_ST_RUN:
         begin
            if (power_down)
               st_next.state = PMCG_ST_SLEEP;
            else if (mode == pmcg_pkg::PMCG_MODE_IDLE)
               st_next.state = PMCG_ST_IDLE;
         end
         PMCG_ST_IDLE:
         begin
            if (mode == pmcg_pkg::PMCG_MODE_NORMAL || wake)
            begin
               st_next.state = PMCG_ST_RUN;
               st_next.pctl[pmcg_pkg::PMCG_POS_MODE +: 2] = 2'h0;
            end
         end
         PMCG_ST_SLEEP:
         begin
            if (wake)
            begin
               st_next.state = PMCG_ST_WARM; // [R03]
               st_next.count = wake_len;
               st_next.pctl[pmcg_pkg::PMCG_POS_MODE +: 2] = 2'h0;
            end
         end
         PMCG_ST_WARM:
         begin
            // crystal counts cpu clocks, external counts osc edges
            if (warm_step)
               st_next.count = st_reg.count - 11'h001; // [R03]
            if (warm_done)
               st_next.state = PMCG_ST_RUN; // [R03]
         end
      endcase
   end

   // state register, asynchronous reset loads constants only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= '0;
         st_reg.pctl <= pmcg_pkg::PMCG_PCTL_RESET;
         st_reg.pgate <= pmcg_pkg::PMCG_PGATE_RESET;
         st_reg.wake_cfg <= pmcg_pkg::PMCG_WAKE_RESET;
         st_reg.state <= PMCG_ST_RUN;
      end
      else
         st_reg <= st_next;
   end

   // baud rate selection
   pmcg_baud_div u_baud
   (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(1'b1),
      .t1_overflow(t1_overflow),
      .baud_doubler(st_reg.pctl[pmcg_pkg::PMCG_POS_BAUD_DBL]),
      .baud_tick(baud_tick)
   );

   // outputs
   assign prdata = st_reg.rdata;
   assign power_mode = mode;
   assign cpu_halted = (st_reg.state != PMCG_ST_RUN);
   // oscillator held for an ungated rtc on the crystal
   assign osc_run = !(st_reg.state == PMCG_ST_SLEEP)
      || (st_reg.wake_cfg[pmcg_pkg::PMCG_POS_RTC_ON_XTAL]
      && !st_reg.pgate[pmcg_pkg::PMCG_POS_RTC_GATE]); // [R06]
   // gate enables, high while the clock runs
   assign uart_clk_en = !st_reg.pgate[pmcg_pkg::PMCG_POS_UART_GATE]
      && !power_down; // [R11]
   assign spi_clk_en = !st_reg.pgate[pmcg_pkg::PMCG_POS_SPI_GATE]
      && !power_down; // [R12]
   assign i2c_clk_en = !st_reg.pgate[pmcg_pkg::PMCG_POS_I2C_GATE]
      && !power_down; // [R13]
   assign rtc_clk_en = !st_reg.pgate[pmcg_pkg::PMCG_POS_RTC_GATE]; // [R16]
   // software must have disabled comparators first
   assign comparator_enable = !st_reg.pgate[pmcg_pkg::PMCG_POS_CMP_PD]
      && !total_pd; // [R14] [R02]
   assign brownout_enable = !total_pd; // [R02]
   assign brownout_reset_req = st_reg.bo_sync[1] && !total_pd; // [R02]
   // watchdog reset only while its clock runs
   assign watchdog_reset_req = st_reg.wd_sync[1]
      && (!power_down || st_reg.wdsel_sync[1]); // [R04]
   // serial bit 7 steering
   assign serial_bit7 = st_reg.pctl[pmcg_pkg::PMCG_POS_FE_LOC]
      ? st_reg.fe_sync[1] : st_reg.sm_sync[1]; // [R09]
   assign user_flag_a = st_reg.pctl[pmcg_pkg::PMCG_POS_FLAG_A]; // [R07]
   assign user_flag_b = st_reg.pctl[pmcg_pkg::PMCG_POS_FLAG_B]; // [R07]
   // level interrupt from unmasked sticky bits
   assign irq = |(st_reg.irq_status & st_reg.irq_mask);
endmodule
